// [core/ibcs_pkg.sv]
/*
 Package for the instruction bus cycle sequencer: cycle kinds, instruction
 classes, address widths and sequence limits.
 Assumes nothing of its surroundings beyond a SystemVerilog elaborator.
*/
package ibcs_pkg;

    // Widths and limits
    localparam int ADDR_W = 24;
    localparam int MAX_CYCLES = 9;
    localparam int MAX_WORDS = 5;
    localparam int WORD_BYTES = 2;

    // Kind of one step in a sequence
    typedef enum logic [2:0] {
        IBCS_CYC_READ_W,
        IBCS_CYC_READ_B,
        IBCS_CYC_WRITE_W,
        IBCS_CYC_WRITE_B,
        IBCS_CYC_IDLE
    } ibcs_cyc_t;

    // Where the address of a step comes from
    typedef enum logic [1:0] {
        IBCS_ADR_WORD,
        IBCS_ADR_NEXT,
        IBCS_ADR_EA
    } ibcs_adr_t;

    // Instruction classes covered
    typedef enum logic [2:0] {
        IBCS_CLS_PLAIN,
        IBCS_CLS_BR8,
        IBCS_CLS_BR16,
        IBCS_CLS_BIT_TEST,
        IBCS_CLS_BIT_RMW
    } ibcs_cls_t;

    localparam logic [2:0] CLS_W_UNUSED = 3'h0;

endpackage

// [core/ibcs_step_if.sv]
/*
 Interface carrying one decoded sequence step from the step table to the
 sequencer. Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ps
interface ibcs_step_if;
    ibcs_pkg::ibcs_cls_t cls;        // Instruction class
    logic [2:0] words;               // Instruction length in words
    logic [3:0] index;               // Step number within the instruction
    ibcs_pkg::ibcs_cyc_t kind;       // Kind of cycle at this step
    ibcs_pkg::ibcs_adr_t src;        // Address source
    logic [2:0] word_no;             // Word number for fetch steps
    logic locked;                    // Bus held after this step
    logic last;                      // Final step of the instruction

    modport table_end (
        input cls, words, index,
        output kind, src, word_no, locked, last
    );
    modport seq_end (
        output cls, words, index,
        input kind, src, word_no, locked, last
    );
endinterface // ibcs_step_if

// [core/ibcs_step_table.sv]
/*
 Step table: maps class, length and step number to one bus cycle.
 Pure combinational; assumes the sequencer only asks for steps in range.
*/
`timescale 1ns/1ps
module ibcs_step_table (
    ibcs_step_if.table_end st // Step query and answer
);

    logic [3:0] nw;
    logic [3:0] i;

    ////////////////////////////////////////////////////////////////////////
    // Fetch extension words first, then the class tail
    always_comb begin
        nw = {1'b0, st.words};
        i = st.index;
        st.kind = ibcs_pkg::IBCS_CYC_READ_W;
        st.src = ibcs_pkg::IBCS_ADR_NEXT;
        st.word_no = 3'h0;
        st.locked = 1'b0;
        st.last = 1'b0;
        if (st.cls == ibcs_pkg::IBCS_CLS_BR8) begin
            // Next sequential read even when not taken
            st.src = (i == 4'h0) ? ibcs_pkg::IBCS_ADR_NEXT
                                 : ibcs_pkg::IBCS_ADR_EA;
            st.last = (i == 4'h1);
        end else if (i + 4'h1 < nw) begin
            st.src = ibcs_pkg::IBCS_ADR_WORD;
            st.word_no = 3'(i + 4'h1);
        end else begin
            case (st.cls)
                ibcs_pkg::IBCS_CLS_BR16: begin
                    // Idle state while target is computed
                    if (i == nw - 4'h1) begin
                        st.kind = ibcs_pkg::IBCS_CYC_IDLE;
                    end else begin
                        st.src = ibcs_pkg::IBCS_ADR_EA;
                        st.last = 1'b1;
                    end
                end
                ibcs_pkg::IBCS_CLS_BIT_TEST: begin
                    if (i == nw - 4'h1) begin
                        st.kind = ibcs_pkg::IBCS_CYC_READ_B;
                        st.src = ibcs_pkg::IBCS_ADR_EA;
                    end else begin
                        st.last = 1'b1;
                    end
                end
                ibcs_pkg::IBCS_CLS_BIT_RMW: begin
                    // Read, prefetch, then write back; first two locked
                    if (i == nw - 4'h1) begin
                        st.kind = ibcs_pkg::IBCS_CYC_READ_B;
                        st.src = ibcs_pkg::IBCS_ADR_EA;
                        st.locked = 1'b1;
                    end else if (i == nw) begin
                        st.locked = 1'b1;
                    end else begin
                        st.kind = ibcs_pkg::IBCS_CYC_WRITE_B;
                        st.src = ibcs_pkg::IBCS_ADR_EA;
                        st.last = 1'b1;
                    end
                end
                default: begin
                    st.last = 1'b1;
                end
            endcase
        end
    end

endmodule // ibcs_step_table

// [core/ibcs_sequencer.sv]
/*
 Instruction bus cycle sequencer: issues the ordered bus cycles of one
 instruction. Assumes the bus answers with a one-cycle done pulse per
 access and that requesters of the bus honour the grant output.
*/
`timescale 1ns/1ps
module ibcs_sequencer #(
    parameter int ADDR_W = ibcs_pkg::ADDR_W
) (
    input wire logic core_clk,                    // System clock
    input wire logic rst_n,                       // Sync reset, low
    input wire logic start,                       // Start an instruction
    input wire ibcs_pkg::ibcs_cls_t cls,          // Instruction class
    input wire logic [2:0] words,                 // Length in words 1..5
    input wire logic [ADDR_W-1:0] pc,             // Instruction start
    input wire logic [ADDR_W-1:0] ea,             // Effective/target address
    input wire logic [7:0] wr_byte,               // Byte to write back
    input wire logic bus_done,                    // Access completed
    input wire logic ext_req,                     // External bus request
    output logic busy,                            // Instruction in progress
    output logic bus_req,                         // Access requested
    output logic bus_write,                       // Write access
    output logic bus_byte,                        // Byte-wide access
    output logic [ADDR_W-1:0] bus_addr,           // Access address
    output logic [15:0] bus_wdata,                // Write data
    output logic bus_locked,                      // Current cycle locked
    output logic ext_grant,                       // Bus handed over
    output logic instr_done                       // Pulse at list end
);

    // Refuse widths too narrow for the word offsets or wider than the bus
    if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ibcs_sequencer: ADDR_W out of range");
    end

    // Issue one step, then wait for its done pulse before the next one
    typedef enum logic [1:0] {
        IBCS_S_IDLE,
        IBCS_S_ISSUE,
        IBCS_S_WAIT
    } ibcs_state_t;

    ibcs_step_if st ();

    ibcs_state_t state, next_state;
    ibcs_pkg::ibcs_cls_t cls_q, next_cls_q;
    logic [2:0] words_q, next_words_q;
    logic [3:0] index, next_index;
    logic [ADDR_W-1:0] pc_q, next_pc_q, ea_q, next_ea_q;
    logic [7:0] wb_q, next_wb_q;
    logic hold, next_hold;
    logic next_bus_req, next_bus_write, next_bus_byte, next_bus_locked;
    logic next_instr_done;
    logic [ADDR_W-1:0] next_bus_addr;
    logic step_bus;

    // Address of word n of the current instruction
    function automatic logic [ADDR_W-1:0] word_addr(
        input logic [ADDR_W-1:0] base,
        input logic [3:0] n
    );
        word_addr = base + ADDR_W'(n) * ADDR_W'(ibcs_pkg::WORD_BYTES);
    endfunction

    // Length actually run: zero counts as one word, an 8-bit branch is one
    // word whatever the decoder said, and no format is longer than five
    function automatic logic [2:0] run_words(
        input ibcs_pkg::ibcs_cls_t c,
        input logic [2:0] w
    );
        if (c == ibcs_pkg::IBCS_CLS_BR8 || w == 3'h0) begin
            run_words = 3'h1;
        end else if (w > 3'(ibcs_pkg::MAX_WORDS)) begin
            run_words = 3'(ibcs_pkg::MAX_WORDS);
        end else begin
            run_words = w;
        end
    endfunction

    // Kind decode for the registered write and width flags
    function automatic logic is_write(input ibcs_pkg::ibcs_cyc_t k);
        is_write = (k == ibcs_pkg::IBCS_CYC_WRITE_B) ||
                   (k == ibcs_pkg::IBCS_CYC_WRITE_W);
    endfunction

    function automatic logic is_byte(input ibcs_pkg::ibcs_cyc_t k);
        is_byte = (k == ibcs_pkg::IBCS_CYC_READ_B) ||
                  (k == ibcs_pkg::IBCS_CYC_WRITE_B);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Step table lookup
    assign st.cls = cls_q;
    assign st.words = words_q;
    assign st.index = index;

    ibcs_step_table u_table (
        .st(st)
    );

    assign step_bus = (st.kind != ibcs_pkg::IBCS_CYC_IDLE);
    assign busy = (state != IBCS_S_IDLE);
    // Grant withheld while a locked cycle or its follower runs
    assign ext_grant = ext_req && !hold && !bus_req && !busy;
    // Byte written back on both lanes so either lane position serves
    assign bus_wdata = {wb_q, wb_q};

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic: one step per issue, waits for bus completion
    always_comb begin
        next_state = state;
        next_cls_q = cls_q;
        next_words_q = words_q;
        next_index = index;
        next_pc_q = pc_q;
        next_ea_q = ea_q;
        next_wb_q = wb_q;
        next_hold = hold;
        next_bus_req = 1'b0;
        next_bus_write = bus_write;
        next_bus_byte = bus_byte;
        next_bus_addr = bus_addr;
        next_bus_locked = bus_locked;
        next_instr_done = 1'b0;
        case (state)
            IBCS_S_IDLE: begin
                if (start) begin
                    next_cls_q = cls;
                    next_words_q = run_words(cls, words);
                    next_pc_q = pc;
                    next_ea_q = ea;
                    next_wb_q = wr_byte;
                    next_index = 4'h0;
                    next_state = IBCS_S_ISSUE;
                end
            end
            IBCS_S_ISSUE: begin
                next_bus_write = is_write(st.kind);
                next_bus_byte = is_byte(st.kind);
                next_bus_locked = st.locked;
                case (st.src)
                    ibcs_pkg::IBCS_ADR_WORD:
                        next_bus_addr = word_addr(pc_q,
                                         {1'b0, st.word_no});
                    ibcs_pkg::IBCS_ADR_EA: next_bus_addr = ea_q;
                    default: next_bus_addr = word_addr(pc_q,
                                         {1'b0, words_q});
                endcase
                if (step_bus) begin
                    next_bus_req = 1'b1;
                    next_state = IBCS_S_WAIT;
                end else if (index < 4'(ibcs_pkg::MAX_CYCLES - 1)) begin
                    // Internal state: one cycle with no access, then on
                    next_index = index + 4'h1;
                end
            end
            IBCS_S_WAIT: begin
                // Request stands until the done pulse is seen
                next_bus_req = !bus_done;
                if (bus_done) begin
                    // Lock covers the cycle after a locked one too
                    next_hold = bus_locked;
                    if (st.last ||
                        index == 4'(ibcs_pkg::MAX_CYCLES - 1)) begin
                        next_instr_done = 1'b1;
                        next_state = IBCS_S_IDLE;
                    end else begin
                        next_index = index + 4'h1;
                        next_state = IBCS_S_ISSUE;
                    end
                end
            end
            default: next_state = IBCS_S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers; reset is sampled on the clock edge, so every
    // reset value is a constant and nothing leaves the clock domain
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= IBCS_S_IDLE;
            cls_q <= ibcs_pkg::IBCS_CLS_PLAIN;
            words_q <= 3'h1;
            index <= 4'h0;
            pc_q <= '0;
            ea_q <= '0;
            wb_q <= 8'h00;
            hold <= 1'b0;
            bus_req <= 1'b0;
            bus_write <= 1'b0;
            bus_byte <= 1'b0;
            bus_addr <= '0;
            bus_locked <= 1'b0;
            instr_done <= 1'b0;
        end else begin
            state <= next_state;
            cls_q <= next_cls_q;
            words_q <= next_words_q;
            index <= next_index;
            pc_q <= next_pc_q;
            ea_q <= next_ea_q;
            wb_q <= next_wb_q;
            hold <= next_hold;
            bus_req <= next_bus_req;
            bus_write <= next_bus_write;
            bus_byte <= next_bus_byte;
            bus_addr <= next_bus_addr;
            bus_locked <= next_bus_locked;
            instr_done <= next_instr_done;
        end
    end

endmodule // ibcs_sequencer

// [tb/ibcs_mem_model.sv]
/*
 Memory model on the sequencer's bus: one done pulse per access after a
 chosen number of wait cycles. Assumes bus_req stands until done is seen.
*/
`timescale 1ns/1ps
module ibcs_mem_model (
    input wire logic core_clk, // System clock
    input wire logic rst_n, // Sync reset, low
    input wire logic bus_req, // Access requested
    input wire logic [1:0] wait_n, // Extra wait cycles
    output logic bus_done // Access completed
);
    logic [1:0] cnt;
    // Count waits, then answer once; never two pulses back to back
    always_ff @(posedge core_clk) begin
        if (!rst_n || !bus_req || bus_done) begin
            cnt <= 2'h0;
            bus_done <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
            bus_done <= (cnt >= wait_n);
        end
    end
endmodule // ibcs_mem_model

// [tb/ibcs_sequencer_sva.sv]
/*
 Checker for the sequencer's ports: request timing, holding and hand-over.
 Assumes one clock domain and a sync active-low reset.
*/
`timescale 1ns/1ps
module ibcs_sequencer_sva #(
    parameter int ADDR_W = 24
) (
    input wire logic core_clk, // System clock
    input wire logic rst_n, // Sync reset, low
    input wire logic start, // Start request
    input wire logic busy, // Instruction running
    input wire logic bus_req, // Access requested
    input wire logic bus_done, // Access completed
    input wire logic bus_write, // Write access
    input wire logic bus_byte, // Byte access
    input wire logic [ADDR_W-1:0] bus_addr, // Access address
    input wire logic bus_locked, // Locked cycle
    input wire logic ext_grant, // Bus handed over
    input wire logic instr_done // List finished
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    logic lock_hold;
    logic next_lock_hold;
    // Remember whether the last finished access was locked
    always_comb begin
        next_lock_hold = lock_hold;
        if (bus_req && bus_done)
            next_lock_hold = bus_locked;
    end
    always_ff @(posedge core_clk) begin
        lock_hold <= rst_n ? next_lock_hold : 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_lock_byte_done;
        bus_req && bus_done && bus_locked && bus_byte;
    endsequence
    sequence s_lock_word_done;
        bus_req && bus_done && bus_locked && !bus_byte;
    endsequence
    sequence s_byte_wback;
        bus_req && bus_write && bus_byte && !bus_locked;
    endsequence
    // Hand-over only when fully idle; a locked access keeps the bus
    chk_grant_idle: assert property (ext_grant |-> !busy && !bus_req)
        else $error("grant while busy");
    chk_lock_keep: assert property (lock_hold |-> !ext_grant)
        else $error("grant after locked cycle");
    chk_start_answer: assert property (start && !busy |-> ##2 bus_req)
        else $error("no access two cycles after start");
    chk_req_hold: assert property (bus_req && !bus_done |=>
        bus_req && $stable(bus_addr) && $stable(bus_write))
        else $error("access dropped or changed early");
    chk_idle_quiet: assert property (!busy |-> !bus_req)
        else $error("access while idle");
    chk_write_byte: assert property (bus_req && bus_write |->
        bus_byte)
        else $error("write not byte wide");
    chk_rmw_order: assert property (s_lock_byte_done |-> ##[1:3]
        (bus_req && bus_locked && !bus_byte && !bus_write))
        else $error("locked word read missing");
    chk_rmw_wback: assert property (s_lock_word_done |->
        ##[1:3] s_byte_wback)
        else $error("write-back missing");
    chk_done_cause: assert property (instr_done |->
        $past(bus_done) || $past(bus_done, 2))
        else $error("done without final access");
endmodule // ibcs_sequencer_sva

// [tb/tb_top.sv]
/*
 Bench for the sequencer: corner and random instructions, each access list
 compared with one worked out here. Assumes the memory model as far side.
*/
`timescale 1ns/1ps
module tb_top;
    localparam int AW = ibcs_pkg::ADDR_W;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    ibcs_pkg::ibcs_cls_t cls = ibcs_pkg::IBCS_CLS_PLAIN;
    logic [2:0] words = 3'h1;
    logic [AW-1:0] pc = '0;
    logic [AW-1:0] ea = '0;
    logic [7:0] wr_byte = 8'h0;
    logic ext_req = 1'b0;
    logic [1:0] wait_n = 2'h0;
    logic bus_done, busy, bus_req, bus_write, bus_byte, bus_locked;
    logic ext_grant, instr_done;
    logic [AW-1:0] bus_addr;
    logic [15:0] bus_wdata;
    logic [AW+2:0] exp_q[$];
    logic [AW+2:0] got_q[$];
    logic running = 1'b0;
    int fail_count = 0;
    int checked = 0;

    ibcs_sequencer ibcs_sequencer_inst (.core_clk, .rst_n, .start, .cls,
        .words, .pc, .ea, .wr_byte, .bus_done, .ext_req, .busy, .bus_req,
        .bus_write, .bus_byte, .bus_addr, .bus_wdata, .bus_locked,
        .ext_grant, .instr_done);
    ibcs_mem_model ibcs_mem_model_inst (.core_clk, .rst_n, .bus_req,
        .wait_n, .bus_done);

    initial forever #5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [AW+2:0] got, input logic [AW+2:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Expected list as {locked, write, byte, address}: fetches, then tail
    function automatic void build(input ibcs_pkg::ibcs_cls_t c,
            input logic [2:0] w);
        int n;
        logic rmw;
        n = (c == ibcs_pkg::IBCS_CLS_BR8 || w == 3'h0) ? 1 : int'(w);
        rmw = (c == ibcs_pkg::IBCS_CLS_BIT_RMW);
        exp_q.delete();
        for (int k = 2; k <= n; k++)
            exp_q.push_back({3'b000,
                pc + AW'(2 * k - 2)});
        if (c == ibcs_pkg::IBCS_CLS_BR16)
            exp_q.push_back({3'b000, ea});
        if (c == ibcs_pkg::IBCS_CLS_BR8)
            exp_q.push_back({3'b000, pc + AW'(2)});
        if (c == ibcs_pkg::IBCS_CLS_BIT_TEST || rmw)
            exp_q.push_back({rmw, 2'b01, ea});
        if (c != ibcs_pkg::IBCS_CLS_BR16 && c != ibcs_pkg::IBCS_CLS_BR8)
            exp_q.push_back({rmw, 2'b00, pc + AW'(2 * n)});
        if (c == ibcs_pkg::IBCS_CLS_BR8)
            exp_q.push_back({3'b000, ea});
        if (rmw)
            exp_q.push_back({3'b011, ea});
    endfunction
    // One instruction; a stray start mid-run must be ignored
    task automatic run(input ibcs_pkg::ibcs_cls_t c, input logic [2:0] w);
        int n;
        pc = AW'($urandom) & ~AW'(1);
        ea = AW'($urandom);
        wr_byte = 8'($urandom);
        wait_n = 2'($urandom);
        build(c, w);
        got_q.delete();
        cls = c;
        words = w;
        start = 1'b1;
        @(posedge core_clk);
        #1 start = 1'b0;
        running = 1'b1;
        if (exp_q.size() >= 3) begin
            @(posedge core_clk);
            #1 start = 1'b1;
            @(posedge core_clk);
            #1 start = 1'b0;
        end
        n = 0;
        while (instr_done !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            #1 n++;
        end
        running = 1'b0;
        check((AW+3)'(n >= 300), '0);
        check((AW+3)'(got_q.size()), (AW+3)'(exp_q.size()));
        foreach (exp_q[i])
            if (i < got_q.size()) check(got_q[i], exp_q[i]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Log finished accesses; a byte write carries the byte on both lanes
    always @(posedge core_clk) begin
        if (rst_n && bus_req === 1'b1 && bus_done === 1'b1) begin
            got_q.push_back({bus_locked, bus_write, bus_byte, bus_addr});
            if (bus_write === 1'b1)
                check((AW+3)'(bus_wdata),
                    (AW+3)'({wr_byte, wr_byte}));
        end
        // No hand-over while an instruction runs, free hand-over otherwise
        if (rst_n === 1'b1)
            check((AW+3)'(ext_grant), (AW+3)'(ext_req && !running));
    end
    // Outside requests at random to probe the hand-over
    initial forever begin
        @(posedge core_clk);
        #1 ext_req = 1'($urandom);
    end
    initial begin
        #100000;
        fail_count++;
        end_of_test();
    end
    initial begin
        ibcs_pkg::ibcs_cls_t c;
        logic [2:0] w;
        void'($urandom(56));
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 60; i++) begin
            if (i == 30) begin
                rst_n = 1'b0;
                repeat (2) @(posedge core_clk);
                #1 rst_n = 1'b1;
            end
            c = ibcs_pkg::ibcs_cls_t'(i % 5);
            w = (i < 10) ? 3'(i % 2 * 5) : 3'($urandom_range(5, 1));
            if (c == ibcs_pkg::IBCS_CLS_BR16)
                w = 3'h2;
            run(c, w);
        end
        end_of_test();
    end
endmodule // tb_top

bind ibcs_sequencer ibcs_sequencer_sva #(.ADDR_W(ADDR_W))
    ibcs_sequencer_sva_inst (.core_clk, .rst_n, .start, .busy, .bus_req,
    .bus_done, .bus_write, .bus_byte, .bus_addr, .bus_locked, .ext_grant,
    .instr_done);
